// ---- rtl/arc_pkg.sv ----
// constants and types for the multi-cycle reclosure sequencer
// assumes one 250 MHz clock and a millisecond tick made from it
package arc_pkg;
  localparam int CLK_MHZ = 250;
  localparam int TICK_US = 1000;
  localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
  localparam int TW = 16;
  localparam int NCYC = 4;
  localparam logic [TW-1:0] TMR_INF = 16'hFFFF;
  localparam logic [NCYC-1:0] SYNC_EN_RST = 4'h0;
  localparam logic [NCYC-1:0] START_EN_RST = 4'hF;
  typedef enum logic [2:0] {
    ARC_IDLE, ARC_ACTION, ARC_TRIPPED, ARC_DEAD, ARC_CLOSE_WAIT, ARC_RECLAIM, ARC_LOCKOUT
  } arc_state_t;
endpackage

// ---- rtl/arc_cycle.sv ----
// reclosure cycle sequencer with status and close indications
// assumes all inputs synchronous to clk_i; settings held stable
`timescale 1ns/1ps
module arc_cycle #(
  parameter int TICK_CYCLES = arc_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // switching
  input wire logic recloser_on_i,
  input wire logic recloser_off_i,
  input wire logic recloser_block_i,
  // start inputs from protection
  input wire logic [2:0] ext_phase_trip_i,
  input wire logic ext_single_pole_trip_i,
  input wire logic ext_three_pole_trip_i,
  input wire logic ext_general_trip_i,
  input wire logic [2:0] ext_phase_pickup_i,
  input wire logic [2:0] ext_fault_pickup_i,
  // block inputs
  input wire logic block_first_cycle_i,
  input wire logic block_second_cycle_i,
  input wire logic block_third_cycle_i,
  input wire logic block_fourth_up_cycles_i,
  input wire logic block_single_pole_cycle_i,
  input wire logic block_three_pole_cycle_i,
  input wire logic [2:0] block_fault_cycle_i,
  // breaker and synchronism check
  input wire logic breaker_ready_i,
  input wire logic sync_release_i,
  // settings
  input wire logic [arc_pkg::NCYC-1:0] start_allow_i,
  input wire logic [arc_pkg::NCYC-1:0] sync_request_en_i,
  input wire logic [arc_pkg::NCYC-1:0] breaker_check_en_i,
  input wire logic adaptive_dead_time_mode_i,
  input wire logic [arc_pkg::TW-1:0] action_time_i,
  input wire logic [arc_pkg::TW-1:0] dead_single_pole_i,
  input wire logic [arc_pkg::TW-1:0] dead_three_pole_i,
  input wire logic [arc_pkg::TW-1:0] dead_one_fault_i,
  input wire logic [arc_pkg::TW-1:0] dead_two_fault_i,
  input wire logic [arc_pkg::TW-1:0] dead_three_fault_i,
  input wire logic [arc_pkg::TW-1:0] dead_evolving_i,
  input wire logic [arc_pkg::TW-1:0] reclaim_time_i,
  input wire logic [arc_pkg::TW-1:0] start_monitor_time_i,
  input wire logic [arc_pkg::TW-1:0] max_dead_time_i,
  input wire logic [arc_pkg::TW-1:0] breaker_window_i,
  // state indications
  output logic recloser_on_o,
  output logic recloser_off_o,
  output logic recloser_blocked_ind_o,
  output logic recloser_not_ready_ind_o,
  output logic reclose_running_ind_o,
  output logic [arc_pkg::NCYC-1:0] cycle_zone_release_o,
  output logic general_zone_release_o,
  output logic sync_check_request_o,
  output logic dead_time_single_pole_running_o,
  output logic dead_time_three_pole_running_o,
  output logic [2:0] dead_time_fault_running_o,
  output logic dead_time_evolving_running_o,
  output logic [arc_pkg::NCYC-1:0] cycle_running_o,
  output logic adaptive_dead_time_running_o,
  output logic reclaim_time_running_o,
  output logic single_pole_trip_permit_o,
  output logic three_pole_trip_cmd_o,
  // event pulses
  output logic reclose_command_o,
  output logic close_first_cycle_single_pole_o,
  output logic close_first_cycle_three_pole_o,
  output logic close_second_cycle_o,
  output logic start_monitor_expired_o,
  output logic max_dead_time_expired_o,
  output logic breaker_ready_window_expired_o,
  output logic reclose_success_ind_o,
  output logic reclose_lockout_ind_o,
  output logic evolving_fault_detected_o
);
  import arc_pkg::*;

  // ---------------------------------------------------------------
  // decoded inputs
  // ---------------------------------------------------------------
  localparam int PW = $clog2(TICK_CYCLES);
  arc_state_t state, next_state;
  logic [PW-1:0] presc;
  logic tick;
  logic [TW-1:0] tmr, mtmr;
  logic [1:0] cur, next_cur, nxt;
  logic on_state, is1p, evol;
  logic [2:0] flt, flt_now;
  logic [NCYC-1:0] cyc_blk, usable;
  logic trip_any, pick_any, trip_1p_now, has_next, go, nr, blocked_c, type_blk, need_sync;
  logic lock_go, ok_close, success, ev_go, sm_exp, md_exp, bw_exp;
  logic [2:0] base;
  logic [TW-1:0] dead_sel;
  logic [1:0] pcnt;

  assign trip_any = |ext_phase_trip_i | ext_single_pole_trip_i | ext_three_pole_trip_i
                    | ext_general_trip_i;
  assign pick_any = |ext_phase_pickup_i | |ext_fault_pickup_i;
  assign trip_1p_now = ext_single_pole_trip_i | ($onehot(ext_phase_trip_i)
                       & !ext_three_pole_trip_i & !ext_general_trip_i);
  assign pcnt = 2'(ext_phase_pickup_i[0]) + 2'(ext_phase_pickup_i[1])
                + 2'(ext_phase_pickup_i[2]);
  assign flt_now = ext_fault_pickup_i | {pcnt == 2'h3, pcnt == 2'h2, pcnt == 2'h1};
  assign cyc_blk = {block_fourth_up_cycles_i, block_third_cycle_i, block_second_cycle_i,
                    block_first_cycle_i};
  assign usable = ~cyc_blk & start_allow_i;
  assign type_blk = (is1p ? block_single_pole_cycle_i : block_three_pole_cycle_i)
                    | |(flt & block_fault_cycle_i);
  assign need_sync = !is1p & sync_request_en_i[cur];

  function automatic logic expired(input logic [TW-1:0] t, input logic [TW-1:0] set);
    expired = (set != TMR_INF) && (t >= set);
  endfunction

  // ---------------------------------------------------------------
  // tick and timers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || tick) begin
      presc <= '0;
    end else begin
      presc <= presc + PW'(1);
    end
  end
  assign tick = (presc == PW'(TICK_CYCLES - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i || next_state != state) begin
      tmr <= '0;
    end else if (tick && tmr != TMR_INF) begin
      tmr <= tmr + TW'(1);
    end
  end

  // time from first trip of a cycle to its close
  always_ff @(posedge clk_i) begin
    if (rst_i || !(state inside {ARC_TRIPPED, ARC_DEAD, ARC_CLOSE_WAIT})) begin
      mtmr <= '0;
    end else if (tick && mtmr != TMR_INF) begin
      mtmr <= mtmr + TW'(1);
    end
  end

  // ---------------------------------------------------------------
  // cycle search and readiness
  // ---------------------------------------------------------------
  always_comb begin
    base = (state == ARC_RECLAIM) ? ({1'b0, cur} + 3'h1) : 3'h0;
    has_next = 1'b0;
    nxt = 2'h0;
    for (int k = NCYC - 1; k >= 0; k--) begin
      if (3'(k) >= base && usable[k]) begin
        has_next = 1'b1;
        nxt = 2'(k);
      end
    end
  end

  always_comb begin
    blocked_c = (state inside {ARC_IDLE, ARC_ACTION}) && (!on_state || recloser_block_i
                || !breaker_ready_i || !has_next);
    nr = blocked_c || state == ARC_LOCKOUT || (state == ARC_RECLAIM && !has_next);
    go = trip_any && !nr && has_next && !recloser_block_i && on_state
         && (state inside {ARC_IDLE, ARC_ACTION, ARC_RECLAIM});
    if (evol) begin
      dead_sel = dead_evolving_i;
    end else if (flt[2]) begin
      dead_sel = dead_three_fault_i;
    end else if (flt[1]) begin
      dead_sel = dead_two_fault_i;
    end else if (flt[0]) begin
      dead_sel = dead_one_fault_i;
    end else begin
      dead_sel = is1p ? dead_single_pole_i : dead_three_pole_i;
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_cur = go ? nxt : cur;
    lock_go = 1'b0;
    ok_close = 1'b0;
    success = 1'b0;
    ev_go = 1'b0;
    sm_exp = 1'b0;
    md_exp = 1'b0;
    bw_exp = 1'b0;
    unique case (state)
      ARC_IDLE, ARC_ACTION: begin
        if (go) begin
          next_state = ARC_TRIPPED;
        end else if (trip_any && on_state) begin
          next_state = ARC_LOCKOUT;
        end else if (state == ARC_ACTION && expired(tmr, action_time_i)) begin
          next_state = ARC_LOCKOUT;
        end else if (state == ARC_ACTION && !pick_any) begin
          next_state = ARC_IDLE;
        end else if (state == ARC_IDLE && pick_any && on_state && !nr) begin
          next_state = ARC_ACTION;
        end
      end
      ARC_TRIPPED, ARC_DEAD, ARC_CLOSE_WAIT: begin
        sm_exp = state == ARC_TRIPPED && trip_any && expired(tmr, start_monitor_time_i);
        md_exp = expired(mtmr, max_dead_time_i);
        bw_exp = state == ARC_CLOSE_WAIT && expired(tmr, breaker_window_i);
        ok_close = state == ARC_CLOSE_WAIT && (!need_sync || sync_release_i)
                   && (!breaker_check_en_i[cur] || breaker_ready_i);
        if (cyc_blk[cur] || type_blk || !on_state || recloser_block_i) begin
          lock_go = 1'b1;
        end else if (sm_exp || md_exp || bw_exp) begin
          lock_go = 1'b1;
        end else if (state == ARC_TRIPPED) begin
          if (!trip_any) begin
            next_state = ARC_DEAD;
          end
        end else if (trip_any) begin
          ev_go = 1'b1;
          next_state = ARC_TRIPPED;
        end else if (state == ARC_DEAD && expired(tmr, dead_sel)) begin
          next_state = ARC_CLOSE_WAIT;
        end else if (ok_close) begin
          next_state = ARC_RECLAIM;
        end
        if (lock_go) begin
          next_state = ARC_LOCKOUT;
        end
      end
      ARC_RECLAIM: begin
        if (go) begin
          next_state = ARC_TRIPPED;
        end else if (trip_any) begin
          lock_go = 1'b1;
          next_state = ARC_LOCKOUT;
        end else if (expired(tmr, reclaim_time_i)) begin
          success = 1'b1;
          next_state = ARC_IDLE;
        end
      end
      ARC_LOCKOUT: begin
        if (!trip_any && !pick_any && expired(tmr, reclaim_time_i)) begin
          next_state = ARC_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ARC_IDLE;
      cur <= 2'h0;
    end else begin
      state <= next_state;
      cur <= next_cur;
    end
  end

  // trip kind latched at each cycle start; evolving marks a retrip in the dead or close-wait phase
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      is1p <= 1'b0;
      flt <= 3'h0;
      evol <= 1'b0;
    end else if (go) begin
      is1p <= trip_1p_now;
      flt <= flt_now;
      evol <= 1'b0;
    end else if (ev_go) begin
      is1p <= 1'b0;
      evol <= 1'b1;
    end
  end

  // off wins over on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      on_state <= 1'b0;
    end else if (recloser_off_i) begin
      on_state <= 1'b0;
    end else if (recloser_on_i) begin
      on_state <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // indications
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reclose_running_ind_o <= 1'b0;
    end else if (go && state != ARC_RECLAIM) begin
      reclose_running_ind_o <= 1'b1;
    end else if (success || next_state == ARC_LOCKOUT) begin
      reclose_running_ind_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      recloser_on_o <= 1'b0;
      recloser_off_o <= 1'b1;
      recloser_blocked_ind_o <= 1'b0;
      recloser_not_ready_ind_o <= 1'b1;
      cycle_zone_release_o <= '0;
      general_zone_release_o <= 1'b0;
      sync_check_request_o <= 1'b0;
      dead_time_single_pole_running_o <= 1'b0;
      dead_time_three_pole_running_o <= 1'b0;
      dead_time_fault_running_o <= 3'h0;
      dead_time_evolving_running_o <= 1'b0;
      cycle_running_o <= '0;
      adaptive_dead_time_running_o <= 1'b0;
      reclaim_time_running_o <= 1'b0;
      single_pole_trip_permit_o <= 1'b0;
      three_pole_trip_cmd_o <= 1'b0;
    end else begin
      recloser_on_o <= on_state;
      recloser_off_o <= !on_state;
      recloser_blocked_ind_o <= blocked_c;
      recloser_not_ready_ind_o <= nr;
      cycle_zone_release_o <= (!nr && has_next) ? (4'h1 << nxt) : 4'h0;
      general_zone_release_o <= !nr && has_next;
      sync_check_request_o <= next_state == ARC_CLOSE_WAIT && need_sync;
      dead_time_single_pole_running_o <= state == ARC_DEAD && !evol && is1p && flt == 3'h0;
      dead_time_three_pole_running_o <= state == ARC_DEAD && !evol && !is1p && flt == 3'h0;
      dead_time_fault_running_o <= (state == ARC_DEAD && !evol) ? flt : 3'h0;
      dead_time_evolving_running_o <= state == ARC_DEAD && evol;
      cycle_running_o <= (state inside {ARC_TRIPPED, ARC_DEAD, ARC_CLOSE_WAIT, ARC_RECLAIM})
                         ? (4'h1 << cur) : 4'h0;
      adaptive_dead_time_running_o <= adaptive_dead_time_mode_i
                                      && (state inside {ARC_DEAD, ARC_CLOSE_WAIT});
      reclaim_time_running_o <= state == ARC_RECLAIM;
      single_pole_trip_permit_o <= !nr && has_next && !block_single_pole_cycle_i;
      three_pole_trip_cmd_o <= trip_any && (nr || !has_next || block_single_pole_cycle_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      reclose_command_o <= 1'b0;
      close_first_cycle_single_pole_o <= 1'b0;
      close_first_cycle_three_pole_o <= 1'b0;
      close_second_cycle_o <= 1'b0;
      start_monitor_expired_o <= 1'b0;
      max_dead_time_expired_o <= 1'b0;
      breaker_ready_window_expired_o <= 1'b0;
      reclose_success_ind_o <= 1'b0;
      reclose_lockout_ind_o <= 1'b0;
      evolving_fault_detected_o <= 1'b0;
    end else begin
      reclose_command_o <= ok_close && !lock_go;
      close_first_cycle_single_pole_o <= ok_close && !lock_go && cur == 2'h0 && is1p;
      close_first_cycle_three_pole_o <= ok_close && !lock_go && cur == 2'h0 && !is1p;
      close_second_cycle_o <= ok_close && !lock_go && cur == 2'h1;
      start_monitor_expired_o <= sm_exp;
      max_dead_time_expired_o <= md_exp;
      breaker_ready_window_expired_o <= bw_exp;
      reclose_success_ind_o <= success;
      reclose_lockout_ind_o <= lock_go;
      evolving_fault_detected_o <= ev_go;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  AST_NR_COVERS_BLK: assert property (@(posedge clk_i) disable iff (rst_i)
    recloser_blocked_ind_o |-> recloser_not_ready_ind_o) else $error("blocked without not ready");
  AST_NO_START_NR: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == ARC_IDLE && nr) |=> state != ARC_TRIPPED) else $error("start while not ready");
  AST_RUN_ON_TRIP: assert property (@(posedge clk_i) disable iff (rst_i)
    (go && state == ARC_IDLE) |=> reclose_running_ind_o && state == ARC_TRIPPED)
    else $error("in progress missing");
  AST_SUCCESS_CLEARS: assert property (@(posedge clk_i) disable iff (rst_i)
    success |=> !reclose_running_ind_o && reclose_success_ind_o && state == ARC_IDLE)
    else $error("success did not clear");
  AST_LOCK_CLEARS: assert property (@(posedge clk_i) disable iff (rst_i)
    lock_go |=> !reclose_running_ind_o && reclose_lockout_ind_o) else $error("lockout kept run");
  AST_SYNC_ONLY_3P: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(sync_check_request_o) |-> !is1p && sync_request_en_i[cur] && state == ARC_CLOSE_WAIT)
    else $error("bad sync request");
  AST_HOLD_FOR_SYNC: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == ARC_CLOSE_WAIT && need_sync && !sync_release_i) |=> !reclose_command_o)
    else $error("closed without release");
  AST_DYN_LOCK: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == ARC_DEAD && cyc_blk[cur]) |=> state == ARC_LOCKOUT) else $error("no lockout");
  AST_ZONE_ONEHOT: assert property (@(posedge clk_i) disable iff (rst_i)
    $onehot0(cycle_zone_release_o) && (general_zone_release_o == |cycle_zone_release_o))
    else $error("zone release not one-hot");

  COV_SUCCESS: cover property (@(posedge clk_i) disable iff (rst_i) reclose_success_ind_o);
  COV_LOCKOUT: cover property (@(posedge clk_i) disable iff (rst_i) reclose_lockout_ind_o);
  COV_SYNC: cover property (@(posedge clk_i) disable iff (rst_i)
    sync_check_request_o ##[1:8] reclose_command_o);
  COV_EVOLVE: cover property (@(posedge clk_i) disable iff (rst_i) evolving_fault_detected_o);
endmodule

// ---- tb/arc_sync_model.sv ----
// far-side model: synchronism check device answering requests
// assumes request and release are sampled on the rising clock edge
`timescale 1ns/1ps
module arc_sync_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // handshake
  input wire logic request_i,
  input wire logic [7:0] delay_i,
  output logic release_o
);
  logic [7:0] cnt;
  // ----------------------------------------
  // release only while a request stands
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || !request_i) begin
      cnt <= 8'h00;
      release_o <= 1'b0;
    end else if (cnt < delay_i) begin
      cnt <= cnt + 8'h01;
    end else begin
      release_o <= 1'b1;
    end
  end
endmodule

// ---- tb/testbench.sv ----
// testbench: reclosure sequencer against a synchronism check model
// assumes a 4-clock tick and the short times set below
`timescale 1ns/1ps
module testbench;
  import arc_pkg::*;
  typedef struct {logic [3:0] trip; logic sync; logic [7:0] dly; logic [10:0] exp;} arc_row_t;
  logic clk_i, rst_i, recloser_on_i, recloser_off_i, recloser_block_i;
  logic [2:0] ext_phase_trip_i, ext_phase_pickup_i, ext_fault_pickup_i, block_fault_cycle_i;
  logic ext_single_pole_trip_i, ext_three_pole_trip_i, ext_general_trip_i;
  logic block_first_cycle_i, block_second_cycle_i, block_third_cycle_i;
  logic block_fourth_up_cycles_i, block_single_pole_cycle_i, block_three_pole_cycle_i;
  logic breaker_ready_i, sync_release_i, adaptive_dead_time_mode_i;
  logic [NCYC-1:0] start_allow_i, sync_request_en_i, breaker_check_en_i;
  logic [TW-1:0] action_time_i, dead_single_pole_i, dead_three_pole_i, dead_one_fault_i;
  logic [TW-1:0] dead_two_fault_i, dead_three_fault_i, dead_evolving_i, reclaim_time_i;
  logic [TW-1:0] start_monitor_time_i, max_dead_time_i, breaker_window_i;
  logic recloser_on_o, recloser_off_o, recloser_blocked_ind_o, recloser_not_ready_ind_o;
  logic reclose_running_ind_o, general_zone_release_o, sync_check_request_o;
  logic [NCYC-1:0] cycle_zone_release_o, cycle_running_o;
  logic dead_time_single_pole_running_o, dead_time_three_pole_running_o;
  logic [2:0] dead_time_fault_running_o;
  logic dead_time_evolving_running_o, adaptive_dead_time_running_o, reclaim_time_running_o;
  logic single_pole_trip_permit_o, three_pole_trip_cmd_o, reclose_command_o;
  logic close_first_cycle_single_pole_o, close_first_cycle_three_pole_o, close_second_cycle_o;
  logic start_monitor_expired_o, max_dead_time_expired_o, breaker_ready_window_expired_o;
  logic reclose_success_ind_o, reclose_lockout_ind_o, evolving_fault_detected_o;
  logic [7:0] sync_dly;
  logic [10:0] seen, mon;
  logic [1:0] seen2;
  int error_cnt, tests_run;
  assign mon = {cycle_running_o[0], start_monitor_expired_o, reclose_lockout_ind_o,
    reclose_success_ind_o, dead_time_three_pole_running_o, dead_time_single_pole_running_o,
    sync_check_request_o, close_second_cycle_o, close_first_cycle_three_pole_o,
    close_first_cycle_single_pole_o, reclose_command_o};
  arc_cycle #(.TICK_CYCLES(4)) u_dut (.*);
  arc_sync_model u_sync (.clk_i(clk_i), .rst_i(rst_i), .request_i(sync_check_request_o),
    .delay_i(sync_dly), .release_o(sync_release_i));
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic switch_on();
    @(posedge clk_i);
    recloser_on_i <= 1'b1;
    @(posedge clk_i);
    recloser_on_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    #1;
    check("on state", {recloser_on_o, recloser_off_o, recloser_not_ready_ind_o}, 3'h4);
  endtask
  // trip kind {phases, general, three-pole, single-pole}; blk sets first-cycle block at drop
  task automatic seq(input logic [3:0] trip, input int hold, input logic blk, input logic ends);
    logic rel;
    int n;
    rel = 1'b0;
    seen = '0;
    seen2 = '0;
    @(posedge clk_i);
    {ext_phase_trip_i, ext_general_trip_i, ext_three_pole_trip_i, ext_single_pole_trip_i} <=
      {{3{trip[3]}}, trip[2:0]};
    for (n = 0; n < hold; n++) begin
      @(posedge clk_i);
      #1;
      if (n == 0 && ends) check("running", reclose_running_ind_o, 1'b1);
      seen |= mon;
      seen2 |= {three_pole_trip_cmd_o, reclaim_time_running_o};
    end
    {ext_phase_trip_i, ext_general_trip_i, ext_three_pole_trip_i, ext_single_pole_trip_i} <= '0;
    block_first_cycle_i <= blk;
    for (n = 0; n < 300; n++) begin
      if (ends && (seen[7] || seen[8])) break;
      @(posedge clk_i);
      #1;
      if (reclose_command_o === 1'b1 && seen[4]) check("release first", rel, 1'b1);
      rel |= sync_release_i;
      seen |= mon;
      seen2 |= {three_pole_trip_cmd_o, reclaim_time_running_o};
    end
    if (ends && n == 300) begin
      check("sequence end", 1'b0, 1'b1);
      report_and_stop();
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    arc_row_t rows [3];
    logic [8:0] blks [5];
    error_cnt = 0;
    tests_run = 0;
    rst_i = 1'b1;
    {recloser_on_i, recloser_off_i, recloser_block_i, ext_phase_trip_i, ext_phase_pickup_i,
      ext_fault_pickup_i, block_fault_cycle_i, ext_single_pole_trip_i, ext_three_pole_trip_i,
      ext_general_trip_i, block_first_cycle_i, block_second_cycle_i, block_third_cycle_i,
      block_fourth_up_cycles_i, block_single_pole_cycle_i, block_three_pole_cycle_i,
      sync_request_en_i, breaker_check_en_i, adaptive_dead_time_mode_i, sync_dly} = '0;
    breaker_ready_i = 1'b1;
    start_allow_i = 4'hF;
    action_time_i = 16'h0005;
    {dead_single_pole_i, dead_three_pole_i, dead_one_fault_i} = {3{16'h0002}};
    {dead_two_fault_i, dead_three_fault_i, dead_evolving_i} = {3{16'h0002}};
    reclaim_time_i = 16'h0003;
    start_monitor_time_i = 16'h0006;
    max_dead_time_i = 16'h0064;
    breaker_window_i = 16'h0032;
    rows = '{'{4'h1, 1'b0, 8'h00, 11'h4A3}, '{4'h2, 1'b0, 8'h00, 11'h4C5},
      '{4'h2, 1'b1, 8'h1E, 11'h4D5}};
    blks = '{9'h040, 9'h080, 9'h020, 9'h00F, 9'h100};
    repeat (6) @(posedge clk_i);
    #1;
    check("reset state", {recloser_on_o, recloser_off_o, recloser_not_ready_ind_o}, 3'h3);
    rst_i <= 1'b0;
    switch_on();
    foreach (rows[i]) begin
      sync_request_en_i <= {3'h0, rows[i].sync};
      sync_dly <= rows[i].dly;
      @(posedge clk_i);
      #1;
      check("zone release", {single_pole_trip_permit_o, general_zone_release_o,
        cycle_zone_release_o}, 6'h31);
      seq(rows[i].trip, 3, 1'b0, 1'b1);
      check("row flags", seen, rows[i].exp);
      check("reclaim running", seen2[0], 1'b1);
      repeat (2) @(posedge clk_i);
      #1;
      check("running cleared", reclose_running_ind_o, 1'b0);
    end
    for (int i = 0; i < 5; i++) begin
      {recloser_off_i, recloser_block_i, block_three_pole_cycle_i, block_single_pole_cycle_i,
        block_fourth_up_cycles_i, block_third_cycle_i, block_second_cycle_i,
        block_first_cycle_i} <= blks[i][7:0];
      breaker_ready_i <= !blks[i][8];
      repeat (3) @(posedge clk_i);
      #1;
      if (i != 2) check("not ready", recloser_not_ready_ind_o, 1'b1);
      if (i == 0 || i == 4) check("blocked", recloser_blocked_ind_o, 1'b1);
      seq(4'h2, 3, blks[i][0], 1'b0);
      check("refused", {seen[8], seen[0]}, {i == 2, 1'b0});
      if (i == 0) check("three-pole trip", seen2[1], 1'b1);
      {recloser_off_i, recloser_block_i, block_three_pole_cycle_i, block_fourth_up_cycles_i,
        block_third_cycle_i, block_second_cycle_i, block_first_cycle_i} <= '0;
      breaker_ready_i <= 1'b1;
      repeat (40) @(posedge clk_i);
      if (i == 1) switch_on();
    end
    start_allow_i <= 4'h3;
    block_first_cycle_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    check("zone skip", cycle_zone_release_o, 4'h2);
    seq(4'h2, 3, 1'b1, 1'b1);
    check("skip flags", seen, 11'h0C9);
    block_first_cycle_i <= 1'b0;
    start_allow_i <= 4'hF;
    repeat (3) @(posedge clk_i);
    seq(4'h4, 3, 1'b1, 1'b1);
    check("dynamic lockout", {seen[8], seen[0]}, 2'h2);
    repeat (2) @(posedge clk_i);
    #1;
    check("running cleared", reclose_running_ind_o, 1'b0);
    block_first_cycle_i <= 1'b0;
    repeat (40) @(posedge clk_i);
    seq(4'h8, 40, 1'b0, 1'b1);
    check("start monitor", {seen[9], seen[8], seen[0]}, 3'h6);
    repeat (40) @(posedge clk_i);
    report_and_stop();
  end
endmodule
